// File: sriov_function_address_map.sv
// ---------------------------------------------------------------
// requester ID insertion on the transmit stream
// ---------------------------------------------------------------
module sriov_function_address_map (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic [fam_pkg::BUS_W-1:0]     captured_bus,
  input  wire logic                          tx_beat_qualifier,
  input  wire logic                          tx_packet_first_beat,
  input  wire logic                          tx_packet_last_beat,
  input  wire logic [fam_pkg::DATA_W-1:0]    tx_data,
  input  wire logic [fam_pkg::PF_INDEX_W-1:0] requester_pf_index,
  input  wire logic [fam_pkg::VF_INDEX_W-1:0] requester_vf_index,
  input  wire logic                          requester_is_vf,
  output logic                               tx_ready,
  output logic                               out_valid,
  input  wire logic                          out_ready,
  output logic                               out_first_beat,
  output logic                               out_last_beat,
  output logic [fam_pkg::DATA_W-1:0]         out_data,
  output logic [fam_pkg::RID_W-1:0]          out_requester_id
);
  import fam_pkg::*;

  // ---------------------------------------------------------------
  // capture of requester indices
  // ---------------------------------------------------------------
  logic [PF_INDEX_W-1:0]  cap_pf;
  logic [VF_INDEX_W-1:0]  cap_vf;
  logic                   cap_is_vf;
  logic [BUS_W-1:0]       cap_bus;
  logic [FUNC_ADDR_W-1:0] func_addr;
  logic [RID_W-1:0]       rid;
  logic [RID_W-1:0]       rid_held;
  pkt_state_type          state;
  pkt_state_type          next_state;
  beat_if                 beat ();

  wire take    = tx_beat_qualifier && tx_ready;
  wire sop_hit = take && tx_packet_first_beat;

  // the bridge trusts the app for index choice
  // indices live only on the first beat
  assign cap_pf    = sop_hit ? requester_pf_index : PF_RESET;
  assign cap_vf    = sop_hit ? requester_vf_index : VF_RESET;
  assign cap_is_vf = sop_hit & requester_is_vf;
  assign cap_bus   = captured_bus;

  func_addr_map u_map (
    .pf_index  (cap_pf),
    .vf_index  (cap_vf),
    .is_vf     (cap_is_vf),
    .func_addr (func_addr)
  );

  // bus in high byte, function in low byte
  assign rid = {cap_bus, func_addr[RID_FUNC_W-1:0]};

  // ---------------------------------------------------------------
  // packet tracking
  // ---------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      IDLE_STATE: if (sop_hit && !tx_packet_last_beat) next_state = BODY_STATE;
      BODY_STATE: if (take && tx_packet_last_beat) next_state = IDLE_STATE;
      default:    next_state = IDLE_STATE;
    endcase
  end

  // state and held RID of the current packet
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state    <= IDLE_STATE;
      rid_held <= '0;
    end
    else
    begin
      state <= next_state;
      if (sop_hit)
      begin
        rid_held <= rid;
      end
    end
  end

  // ---------------------------------------------------------------
  // header insertion into the buffered stream
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] hdr_data;
  logic              fifo_valid;
  logic [BEAT_W-1:0] fifo_data;

  // overwrite the header RID field on the first beat
  always_comb
  begin
    hdr_data = tx_data;
    if (tx_packet_first_beat)
    begin
      hdr_data[RID_HDR_LSB +: RID_W] = rid;
    end
  end

  assign beat.valid = tx_beat_qualifier;
  assign beat.data  = {tx_packet_first_beat, tx_packet_last_beat, hdr_data};
  assign tx_ready   = beat.ready;

  beat_fifo #(
    .WIDTH (BEAT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .fill      (beat),
    .out_valid (fifo_valid),
    .out_ready (out_ready),
    .out_data  (fifo_data)
  );

  assign out_valid      = fifo_valid;
  assign out_first_beat = fifo_valid & fifo_data[BEAT_W-1];
  assign out_last_beat  = fifo_valid & fifo_data[BEAT_W-2];
  assign out_data       = fifo_data[DATA_W-1:0];
  assign out_requester_id = rid_held;
endmodule : sriov_function_address_map

// File: fam_pkg.sv
// Behaviour
// - at most eight PFs, 2048 VFs
// - address map static, from configured counts
// - PFs take addresses from zero, contiguous
// - VFs follow PFs, grouped per PF
// - VF offset and stride are constants
// - four PFs: PF0 VFs start at 4
// - no SR-IOV: PF i at address i
// - one PF: VF j at j+1
// - two PFs: VF start 2, then N0+2
// - three PFs: VFs start at 3
// - capture indices on first beat and valid
// - build requester ID, insert into header
package fam_pkg;
  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int MAX_PF          = 8;
  localparam int MAX_VF          = 2048;
  localparam int PF_INDEX_W      = 3;
  localparam int VF_INDEX_W      = 11;
  localparam int FUNC_ADDR_W     = 12;
  localparam int BUS_W           = 8;
  localparam int RID_W           = 16;
  localparam int DATA_W          = 128;
  localparam int FIFO_DEPTH      = 4;
  localparam int RID_HDR_LSB     = 48;
  localparam int RID_BUS_LSB     = 8;
  localparam int RID_FUNC_W      = 8;
  localparam int BEAT_W          = DATA_W + 2;
  // ---------------------------------------------------------------
  // configured map: generation-time constants
  // ---------------------------------------------------------------
  localparam int NUM_PF          = 4;
  localparam logic [VF_INDEX_W:0] VF_COUNT [MAX_PF] = '{
    12'h004, 12'h002, 12'h003, 12'h001, 12'h000, 12'h000, 12'h000, 12'h000};
  localparam logic [FUNC_ADDR_W-1:0] VF_STRIDE = 12'h001;
  localparam logic [BUS_W-1:0] BUS_RESET     = 8'h00;
  localparam logic [PF_INDEX_W-1:0] PF_RESET = 3'h0;
  localparam logic [VF_INDEX_W-1:0] VF_RESET = 11'h000;

  typedef enum logic [1:0] {
    IDLE_STATE = 2'b01,
    BODY_STATE = 2'b10
  } pkt_state_type;

  // first VF address of one PF: PFs first, then earlier PFs' VFs
  function automatic logic [FUNC_ADDR_W-1:0] vf_offset(input int pf);
    int sum;
    sum = NUM_PF;
    for (int k = 0; k < MAX_PF; k++)
    begin
      if (k < pf)
      begin
        sum = sum + int'(VF_COUNT[k]);
      end
    end
    return FUNC_ADDR_W'(sum);
  endfunction : vf_offset
endpackage : fam_pkg

// File: beat_if.sv
// carries one stream beat between the tagger and the FIFO
interface beat_if;
  import fam_pkg::*;
  logic              valid;
  logic              ready;
  logic [BEAT_W-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface : beat_if

// File: beat_fifo.sv
// ---------------------------------------------------------------
// small stream FIFO with honest full and empty
// ---------------------------------------------------------------
module beat_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  beat_if.sink                  fill,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = fill.valid && fill.ready;
  wire              pop  = out_valid && out_ready;

  // handshake and head word
  assign fill.ready = (count != (AW+1)'(DEPTH));
  assign out_valid  = (count != '0);
  assign out_data   = mem[rd_ptr];

  // pointers and occupancy
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
      begin
        mem[wr_ptr] <= fill.data;
        wr_ptr      <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : beat_fifo

// File: func_addr_map.sv
// ---------------------------------------------------------------
// static function address lookup
// ---------------------------------------------------------------
module func_addr_map (
  input  wire logic [fam_pkg::PF_INDEX_W-1:0]  pf_index,
  input  wire logic [fam_pkg::VF_INDEX_W-1:0]  vf_index,
  input  wire logic                            is_vf,
  output logic      [fam_pkg::FUNC_ADDR_W-1:0] func_addr
);
  import fam_pkg::*;
  logic [FUNC_ADDR_W-1:0] offset_table [MAX_PF];

  // constant per-PF first VF address, never written at run time
  for (genvar g = 0; g < MAX_PF; g++)
  begin : g_off
    assign offset_table[g] = vf_offset(g);
  end

  // PF at its own index, VF at offset plus index times stride
  assign func_addr = is_vf
    ? FUNC_ADDR_W'(offset_table[pf_index] + VF_STRIDE * FUNC_ADDR_W'(vf_index))
    : FUNC_ADDR_W'(pf_index);
endmodule : func_addr_map

// File: fam_monitor.sv
// ---------------------------------------------------------------
// port checker for requester ID insertion
// ---------------------------------------------------------------
module fam_monitor (
  input wire logic          clk,
  input wire logic          rst,
  input wire logic [7:0]    captured_bus,
  input wire logic          tx_beat_qualifier,
  input wire logic          tx_packet_first_beat,
  input wire logic [2:0]    requester_pf_index,
  input wire logic [10:0]   requester_vf_index,
  input wire logic          requester_is_vf,
  input wire logic          tx_ready,
  input wire logic          out_valid,
  input wire logic          out_ready,
  input wire logic [127:0]  out_data,
  input wire logic [15:0]   out_requester_id
);
  timeunit 1ns;
  timeprecision 1ns;
  import fam_pkg::*;
  // accepted beat, accepted first beat, accepted first beat of a VF
  wire take = tx_beat_qualifier && tx_ready;
  wire sop  = take && tx_packet_first_beat;
  wire vf   = sop && requester_is_vf;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_pf; sop && !requester_is_vf |=>
    out_requester_id == {$past(captured_bus), 5'h00, $past(requester_pf_index)}; endproperty
  a_pf: assert property (p_pf) else $error("pf address wrong");
  property p_vf0; vf && requester_pf_index == 3'h0 |=>
    out_requester_id[7:0] == 8'h04 + 8'($past(requester_vf_index)); endproperty
  a_vf0: assert property (p_vf0) else $error("pf0 vf address wrong");
  property p_vf1; vf && requester_pf_index == 3'h1 |=> out_requester_id[7:0] ==
    8'h04 + 8'(VF_COUNT[0]) + 8'($past(requester_vf_index)); endproperty
  a_vf1: assert property (p_vf1) else $error("pf1 vf address wrong");
  property p_bus; sop |=> out_requester_id[15:8] == $past(captured_bus); endproperty
  a_bus: assert property (p_bus) else $error("bus byte wrong");
  property p_hold; !sop |=> $stable(out_requester_id); endproperty
  a_hold: assert property (p_hold) else $error("id moved off first beat");
  property p_rst; disable iff (1'b0) rst |=> !out_valid && out_requester_id == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_fill; take && !out_valid |=> out_valid; endproperty
  a_fill: assert property (p_fill) else $error("beat not forwarded");
  property p_keep; out_valid && !out_ready |=> out_valid && $stable(out_data); endproperty
  a_keep: assert property (p_keep) else $error("head word lost");
endmodule : fam_monitor

bind sriov_function_address_map fam_monitor fam_monitor_i (.clk, .rst, .captured_bus,
  .tx_beat_qualifier, .tx_packet_first_beat, .requester_pf_index, .requester_vf_index,
  .requester_is_vf, .tx_ready, .out_valid, .out_ready, .out_data, .out_requester_id);

// File: app_tx_model.sv
// ---------------------------------------------------------------
// application side: sends transmit packets
// ---------------------------------------------------------------
module app_tx_model (
  input  wire logic         clk,
  input  wire logic         tx_ready,
  output logic              qual,
  output logic              first,
  output logic              last,
  output logic [127:0]      data,
  output logic [2:0]        pf,
  output logic [10:0]       vf,
  output logic              is_vf,
  output logic              stuck
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle at time zero
  initial
  begin
    {qual, first, last, is_vf, stuck} = 5'h00;
    data = '1;
    pf = 3'h7;
    vf = 11'h7FF;
  end
  // one packet, each beat held until the edge that takes it
  task automatic send(input logic [2:0] p, input logic [10:0] v, input logic f, input int n);
    int k;
    for (int b = 0; b < n; b++)
    begin
      @(negedge clk);
      qual  = 1'b1;
      first = (b == 0);
      last  = (b == n - 1);
      data  = {8{16'hC3C3 ^ 16'(b)}};
      pf    = (b == 0) ? p : ~p; // later beats carry junk indices
      vf    = (b == 0) ? v : ~v;
      is_vf = f;
      k = 0;
      while (!tx_ready && k < 40)
      begin
        @(negedge clk);
        k++;
      end
      stuck = stuck | (k == 40);
      @(posedge clk);
    end
    @(negedge clk);
    qual  = 1'b0;
    data  = ~data; // released data and index lines never keep the old value; first and last keep theirs
    pf    = ~pf;
    vf    = ~vf;
    is_vf = ~is_vf;
  endtask : send
endmodule : app_tx_model

// File: sriov_function_address_map_tb.sv
// ---------------------------------------------------------------
// self-checking bench
// ---------------------------------------------------------------
module sriov_function_address_map_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, qual, first, last, is_vf, stuck, tx_ready, out_valid, out_ready, of, ol;
  logic [7:0] bus;
  logic [127:0] data, odata;
  logic [2:0] pf;
  logic [10:0] vf;
  logic [15:0] rid, e;
  int err_total, checked;

  sriov_function_address_map sriov_function_address_map_i (.clk(clk), .rst(rst),
    .captured_bus(bus), .tx_beat_qualifier(qual), .tx_packet_first_beat(first),
    .tx_packet_last_beat(last), .tx_data(data), .requester_pf_index(pf),
    .requester_vf_index(vf), .requester_is_vf(is_vf), .tx_ready(tx_ready),
    .out_valid(out_valid), .out_ready(out_ready), .out_first_beat(of),
    .out_last_beat(ol), .out_data(odata), .out_requester_id(rid));
  app_tx_model app_tx_model_i (.clk(clk), .tx_ready(tx_ready), .qual(qual), .first(first),
    .last(last), .data(data), .pf(pf), .vf(vf), .is_vf(is_vf), .stuck(stuck));

  // 50 ns clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // expected function address from the static map
  function automatic logic [7:0] fa(input int p, input int v, input bit f);
    int b;
    b = 4;
    for (int k = 0; k < p; k++)
      b += int'(fam_pkg::VF_COUNT[k]);
    return f ? 8'(b + v) : 8'(p);
  endfunction : fa

  // take one word off the output: flags, payload and, on beat 0, the header field
  task automatic pop(input logic [15:0] exp, input int b, input bit lst);
    int k;
    k = 0;
    while (out_valid !== 1'b1 && k < 40)
    begin
      @(negedge clk);
      k++;
    end
    if (k == 40)
    begin
      err_total++;
      test_done();
    end
    if (b == 0)
      chk(odata[63:48], exp);
    chk({14'h0000, of, ol}, {14'h0000, b == 0, lst});
    chk(odata[15:0], 16'hC3C3 ^ 16'(b));
    out_ready = 1'b1;
    @(negedge clk);
    out_ready = 1'b0;
    @(negedge clk); // let an edge pass before the next pop raises ready again
  endtask : pop

  task automatic t_pf();
    for (int p = 0; p < 4; p++)
    begin
      e = {bus, fa(p, 0, 0)};
      app_tx_model_i.send(3'(p), 11'h000, 1'b0, 1);
      chk(rid, e);
      pop(e, 0, 1'b1);
    end
    $display("pf map done");
  endtask : t_pf

  task automatic t_vf();
    for (int p = 0; p < 4; p++)
      for (int v = 0; v < int'(fam_pkg::VF_COUNT[p]); v++)
      begin
        e = {bus, fa(p, v, 1)};
        app_tx_model_i.send(3'(p), 11'(v), 1'b1, 2);
        chk(rid, e);
        pop(e, 0, 1'b0);
        pop(e, 1, 1'b1);
      end
    $display("vf map done");
  endtask : t_vf

  task automatic t_hold();
    bus = 8'hC3;
    e = {8'hC3, fa(1, 1, 1)};
    app_tx_model_i.send(3'h1, 11'h001, 1'b1, 3);
    bus = 8'h3C;
    repeat (3) @(negedge clk);
    chk(rid, e);
    pop(e, 0, 1'b0);
    pop(e, 1, 1'b0);
    pop(e, 2, 1'b1);
    $display("hold done");
  endtask : t_hold

  task automatic t_full();
    for (int v = 0; v < 3; v++)
      app_tx_model_i.send(3'h2, 11'(v), 1'b1, 1);
    app_tx_model_i.send(3'h0, 11'h000, 1'b0, 1);
    chk(16'(tx_ready), 16'h0000);
    for (int v = 0; v < 3; v++)
      pop({bus, fa(2, v, 1)}, 0, 1'b1);
    pop({bus, 8'h00}, 0, 1'b1);
    chk(16'(stuck), 16'h0000);
    $display("full done");
  endtask : t_full

  // reset, then the scenarios in turn
  initial
  begin
    err_total = 0;
    checked = 0;
    rst = 1'b1;
    out_ready = 1'b0;
    bus = 8'h5A;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_pf();
    t_vf();
    t_hold();
    t_full();
    test_done();
  end
endmodule : sriov_function_address_map_tb
